// File: inc/flash_access_pkg.sv
`default_nettype none
package flash_access_pkg;

    // Register addresses in the special-function space
    localparam logic [7:0] ADDR_KEY_LOCK     = 8'hb7;
    localparam logic [7:0] ADDR_STROBE_PER   = 8'hbe;
    localparam logic [7:0] ADDR_CACHE_CTRL   = 8'he3;

    // Reset values
    localparam logic [7:0] RST_KEY_LOCK      = 8'h00;
    localparam logic [3:0] RST_STROBE_PER    = 4'hf;
    localparam logic [7:0] RST_CACHE_CTRL    = 8'h20;

    // Key codes
    localparam logic [7:0] KEY_FIRST         = 8'ha5;
    localparam logic [7:0] KEY_SECOND        = 8'hf1;

    // Field positions
    localparam int         POS_PREFETCH      = 5;
    localparam int         POS_BLOCK_WRITE   = 0;
    localparam int         STROBE_PER_W      = 4;

    // Above this system clock rate the strobe limiter is bypassed, unless slow read timing is selected
    localparam int         STROBE_LIMIT_KHZ  = 12500;

    typedef enum logic [1:0] {
        LOCK_CLOSED  = 2'b00,
        LOCK_HALF    = 2'b01,
        LOCK_OPEN    = 2'b10,
        LOCK_DEAD    = 2'b11
    } lock_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic        erase;
        logic        pair;
        logic [15:0] addr;
        logic [15:0] data;
    } prog_cmd_s;

endpackage
`default_nettype wire

// File: src/key_sequencer.sv
`default_nettype none
module key_sequencer
    import flash_access_pkg::*;
(
    input  wire logic        core_clk,   // System clock
    input  wire logic        rst_b,      // Async reset, active low
    input  wire logic        key_wr,     // Key register written
    input  wire logic [7:0]  key_val,    // Value written
    input  wire logic        op_try,     // Write or erase attempted
    input  wire logic        op_done,    // Array finished operation
    output lock_state_e      lock_state, // Current lock state
    output logic             write_ok    // Operations permitted
);

    lock_state_e next_lock_state;
    logic        busy;

    assign write_ok = (lock_state == LOCK_OPEN);

    always_comb begin
        next_lock_state = lock_state;
        unique case (lock_state)
            LOCK_CLOSED: begin
                if (op_try) begin
                    next_lock_state = LOCK_DEAD;
                end else if (key_wr) begin
                    next_lock_state = (key_val == KEY_FIRST) ?
                                      LOCK_HALF : LOCK_DEAD;
                end
            end
            LOCK_HALF: begin
                if (op_try) begin
                    next_lock_state = LOCK_DEAD;
                end else if (key_wr) begin
                    next_lock_state = (key_val == KEY_SECOND) ?
                                      LOCK_OPEN : LOCK_DEAD;
                end
            end
            LOCK_OPEN: begin
                if (busy && op_done) begin
                    next_lock_state = LOCK_CLOSED;
                end else if (key_wr) begin
                    next_lock_state = LOCK_DEAD;
                end
            end
            LOCK_DEAD: next_lock_state = LOCK_DEAD;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_state <= LOCK_CLOSED;
        end else begin
            lock_state <= next_lock_state;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (op_try && write_ok) begin
            busy <= 1'b1;
        end else if (op_done || lock_state != LOCK_OPEN) begin
            busy <= 1'b0;
        end
    end

    a_key_first_step: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        key_wr && !op_try && lock_state == LOCK_CLOSED
            && key_val == KEY_FIRST |=> lock_state == LOCK_HALF)
        else $error("first key not accepted");

    a_auto_relock: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        lock_state == LOCK_OPEN && busy && op_done
            |=> lock_state == LOCK_CLOSED)
        else $error("no relock after operation");

    a_open_in_flight: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        write_ok && busy && !op_done && !key_wr |=> write_ok)
        else $error("unlock lost before operation ended");

    a_bad_key_dead: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        key_wr && lock_state == LOCK_HALF && key_val != KEY_SECOND
            |=> lock_state == LOCK_DEAD)
        else $error("bad key did not lock out");

    a_refuse_locked: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        op_try && !write_ok |=> lock_state == LOCK_DEAD ##1
            lock_state == LOCK_DEAD)
        else $error("attempt while locked not punished");

    a_dead_sticks: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        lock_state == LOCK_DEAD |=> $stable(lock_state))
        else $error("lockout released without reset");

    a_other_value: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        key_wr && lock_state == LOCK_CLOSED && key_val != KEY_FIRST
            |=> lock_state == LOCK_DEAD)
        else $error("non-key value did not lock out");

endmodule
`default_nettype wire

// File: src/read_strobe_limiter.sv
`default_nettype none
module read_strobe_limiter
    import flash_access_pkg::*;
#(
    parameter int PER_W = STROBE_PER_W
) (
    input  wire logic             core_clk,  // System clock
    input  wire logic             rst_b,     // Async reset, active low
    input  wire logic             sys_tick,  // Start of a system cycle
    input  wire logic             rd_req,    // Array read this cycle
    input  wire logic [PER_W-1:0] period,    // Strobe width minus one
    input  wire logic             bypass,    // Limiter disabled
    output logic                  strobe,    // Array read strobe
    output logic                  low_power  // Array in low power
);

    logic [PER_W-1:0] left;
    logic [PER_W:0]   width;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe <= 1'b0;
            left   <= '0;
        end else if (sys_tick) begin
            strobe <= rd_req;
            left   <= period;
        end else if (strobe && !bypass) begin
            if (left == '0) begin
                strobe <= 1'b0;
            end
            left <= left - 1'b1;
        end
    end

    // low power for rest of cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_power <= 1'b0;
        end else if (sys_tick) begin
            low_power <= 1'b0;
        end else if (strobe && !bypass && left == '0) begin
            low_power <= 1'b1;
        end
    end

    // Helper: length of the current strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            width <= '0;
        end else if (sys_tick) begin
            width <= '0;
        end else if (strobe) begin
            width <= width + 1'b1;
        end
    end

    a_strobe_width: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(strobe) && !$past(sys_tick) && !$past(bypass)
            |-> width == {1'b0, $past(period)} + 1'b1)
        else $error("strobe width differs from period");

    a_low_power: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(strobe) && !$past(sys_tick) |-> low_power)
        else $error("array not in low power after strobe");

    a_low_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        low_power && !sys_tick |=> low_power)
        else $error("low power left before next cycle");

    a_no_limit: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        strobe && bypass && !sys_tick |=> strobe)
        else $error("strobe cut while limiter bypassed");

endmodule
`default_nettype wire

// File: src/flash_access_control.sv
`default_nettype none
module flash_access_control
    import flash_access_pkg::*;
(
    input  wire logic        core_clk,        // System clock, 200 MHz
    input  wire logic        rst_b,           // Async reset, active low
    input  wire sfr_req_s    sfr_req,         // Register access
    output logic [7:0]       sfr_rdata,       // Register read data
    input  wire logic        flash_wr_req,    // Software byte write
    input  wire logic        flash_erase_req, // Software page erase
    input  wire logic [15:0] flash_addr,      // Target address
    input  wire logic [7:0]  flash_wdata,     // Byte to write
    input  wire logic        flash_op_done,   // Array finished, pulse
    output prog_cmd_s        prog_cmd,        // Command to array
    output logic             prog_start,      // Command valid, pulse
    output logic             op_refused,      // Attempt refused, pulse
    output logic [1:0]       lock_state,      // Current lock code
    output logic             prefetch_enable, // Prefetch engine on
    input  wire logic        sys_tick,        // System cycle start
    input  wire logic        flash_read_req,  // Array read this cycle
    input  wire logic        sysclk_fast,     // System clock fast
    input  wire logic        flash_read_timing_select, // Slow timing
    output logic             read_strobe,     // Array read strobe
    output logic             array_low_power  // Array low power
);

    logic [7:0]  cache_ctrl;
    logic [3:0]  strobe_period;
    logic        block_write_enable;
    logic        key_wr;
    logic        op_req;
    logic        op_try;
    logic        write_ok;
    logic        busy;
    logic        pend;
    logic [15:0] pend_addr;
    logic [7:0]  pend_byte;
    lock_state_e key_state;

    assign block_write_enable = cache_ctrl[POS_BLOCK_WRITE];
    assign key_wr = sfr_req.wr && sfr_req.addr == ADDR_KEY_LOCK;
    assign op_req = (flash_wr_req || flash_erase_req) && !busy;
    // First byte of a pair only arms once the sequence is open
    assign op_try = op_req && (flash_erase_req || !block_write_enable
                               || pend || !write_ok);

    key_sequencer u_keys (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .key_wr     (key_wr),
        .key_val    (sfr_req.wdata),
        .op_try     (op_try),
        .op_done    (flash_op_done),
        .lock_state (key_state),
        .write_ok   (write_ok)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cache_ctrl <= RST_CACHE_CTRL;
        end else if (sfr_req.wr && sfr_req.addr == ADDR_CACHE_CTRL) begin
            cache_ctrl <= sfr_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prefetch_enable <= RST_CACHE_CTRL[POS_PREFETCH];
        end else if (sfr_req.wr && sfr_req.addr == ADDR_CACHE_CTRL) begin
            prefetch_enable <= sfr_req.wdata[POS_PREFETCH];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_period <= RST_STROBE_PER;
        end else if (sfr_req.wr && sfr_req.addr == ADDR_STROBE_PER) begin
            strobe_period <= sfr_req.wdata[STROBE_PER_W-1:0];
        end
    end

    // Register reads
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= RST_KEY_LOCK;
        end else if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                ADDR_KEY_LOCK:   sfr_rdata <= {6'h00, key_state};
                ADDR_STROBE_PER: sfr_rdata <= {4'h0, strobe_period};
                ADDR_CACHE_CTRL: sfr_rdata <= cache_ctrl;
                default:         sfr_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_state <= LOCK_CLOSED;
        end else begin
            lock_state <= key_state;
        end
    end

    // hold first byte of a pair
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend      <= 1'b0;
            pend_addr <= 16'h0000;
            pend_byte <= 8'h00;
        end else if (!block_write_enable || !write_ok) begin
            // Half pair is dropped if the mode or lock changes
            pend <= 1'b0;
        end else if (op_req && flash_wr_req && !pend) begin
            pend      <= 1'b1;
            pend_addr <= flash_addr;
            pend_byte <= flash_wdata;
        end else if (op_try) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_refused <= 1'b0;
        end else begin
            op_refused <= op_try && !write_ok;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_start <= 1'b0;
            prog_cmd   <= '0;
        end else begin
            prog_start <= op_try && write_ok;
            if (op_try && write_ok) begin
                prog_cmd.erase <= flash_erase_req;
                if (flash_erase_req || !block_write_enable) begin
                    prog_cmd.pair <= 1'b0;
                    prog_cmd.addr <= flash_addr;
                    prog_cmd.data <= {8'h00, flash_wdata};
                end else begin
                    prog_cmd.pair <= 1'b1;
                    prog_cmd.addr <= pend_addr;
                    prog_cmd.data <= {flash_wdata, pend_byte};
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else if (op_try && write_ok) begin
            busy <= 1'b1;
        end else if (flash_op_done) begin
            busy <= 1'b0;
        end
    end

    read_strobe_limiter #(
        .PER_W (STROBE_PER_W)
    ) u_strobe (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .sys_tick  (sys_tick),
        .rd_req    (flash_read_req),
        .period    (strobe_period),
        // bypass when fast and default timing
        .bypass    (sysclk_fast && !flash_read_timing_select),
        .strobe    (read_strobe),
        .low_power (array_low_power)
    );

    a_key_readback: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        sfr_req.rd && sfr_req.addr == ADDR_KEY_LOCK
            |=> sfr_rdata == {6'h00, $past(key_state)})
        else $error("key register read is not lock state");

    a_lock_code: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        write_ok |=> lock_state == 2'b10)
        else $error("unlocked state code not 10");

    a_prefetch_follow: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        sfr_req.wr && sfr_req.addr == ADDR_CACHE_CTRL
            |=> prefetch_enable == $past(sfr_req.wdata[POS_PREFETCH]))
        else $error("prefetch enable does not follow bit 5");

    a_single_byte: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        op_req && flash_wr_req && !flash_erase_req && write_ok
            && !block_write_enable |=> prog_start && !prog_cmd.pair)
        else $error("single byte write not issued alone");

    a_pair_write: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        prog_start && !prog_cmd.erase |-> prog_cmd.pair ==
            $past(block_write_enable))
        else $error("pairing differs from block write bit");

    a_upper_zero: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        sfr_req.rd && sfr_req.addr == ADDR_STROBE_PER
            |=> sfr_rdata[7:4] == 4'h0)
        else $error("period register upper bits not zero");

    a_period_store: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        sfr_req.wr && sfr_req.addr == ADDR_STROBE_PER
            |=> strobe_period == $past(sfr_req.wdata[STROBE_PER_W-1:0]))
        else $error("period field not stored");

    a_refuse_pulse: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        op_try && !write_ok |=> op_refused && !prog_start)
        else $error("refused attempt reached the array");

    a_half_code: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        key_state == LOCK_HALF |=> lock_state == 2'b01)
        else $error("first key state code not 01");

    a_erase_single: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        prog_start && prog_cmd.erase |-> !prog_cmd.pair)
        else $error("erase issued as a pair");

endmodule
`default_nettype wire

// File: verification/flash_array_model.sv
`default_nettype none
module flash_array_model
    import flash_access_pkg::*;
(
    input  wire logic      core_clk,      // System clock
    input  wire logic      rst_b,         // Async reset, active low
    input  wire logic      prog_start,    // Command issued
    input  wire prog_cmd_s prog_cmd,      // Command contents
    input  wire logic      slow,          // Long busy time
    output logic           flash_op_done  // Completion pulse
);
    timeunit 1ns;
    timeprecision 100ps;

    int unsigned busy_cnt;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt      <= 0;
            flash_op_done <= 1'h0;
        end else begin
            flash_op_done <= (busy_cnt == 1);
            if (prog_start) begin
                // Erase takes longer than a byte program, except when slow, where both take 20
                busy_cnt <= slow ? 20 : (prog_cmd.erase ? 6 : 3);
            end else if (busy_cnt != 0) begin
                busy_cnt <= busy_cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/flash_access_control_tb.sv
`default_nettype none
module flash_access_control_tb
    import flash_access_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk;
    logic        rst_b;
    sfr_req_s    sfr_req;
    logic [7:0]  sfr_rdata;
    logic        flash_wr_req;
    logic        flash_erase_req;
    logic [15:0] flash_addr;
    logic [7:0]  flash_wdata;
    logic        flash_op_done;
    prog_cmd_s   prog_cmd;
    logic        prog_start;
    logic        op_refused;
    logic [1:0]  lock_state;
    logic        prefetch_enable;
    logic        sys_tick;
    logic        flash_read_req;
    logic        sysclk_fast;
    logic        flash_read_timing_select;
    logic        read_strobe;
    logic        array_low_power;
    logic        slow;
    logic [7:0]  bad_key [3];
    int          fail_count;
    int          total_checks;

    flash_access_control flash_access_control_inst (
        .core_clk(core_clk), .rst_b(rst_b),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .flash_wr_req(flash_wr_req), .flash_erase_req(flash_erase_req),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_op_done(flash_op_done), .prog_cmd(prog_cmd),
        .prog_start(prog_start), .op_refused(op_refused),
        .lock_state(lock_state), .prefetch_enable(prefetch_enable),
        .sys_tick(sys_tick), .flash_read_req(flash_read_req),
        .sysclk_fast(sysclk_fast),
        .flash_read_timing_select(flash_read_timing_select),
        .read_strobe(read_strobe), .array_low_power(array_low_power)
    );

    flash_array_model flash_array_model_inst (
        .core_clk(core_clk), .rst_b(rst_b), .prog_start(prog_start),
        .prog_cmd(prog_cmd), .slow(slow), .flash_op_done(flash_op_done)
    );

    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // Lands just after the n-th rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        rst_b = 1'h0;
        cyc(5);
        rst_b = 1'h1;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_req.addr = a;
        sfr_req.wdata = d;
        sfr_req.wr = 1'h1;
        cyc(1);
        sfr_req.wr = 1'h0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        sfr_req.addr = a;
        sfr_req.rd = 1'h1;
        cyc(1);
        sfr_req.rd = 1'h0;
        chk(sfr_rdata, exp, "register read");
    endtask

    task automatic flash_op(input logic erase, input logic [15:0] a,
                            input logic [7:0] d);
        @(posedge core_clk);
        #1;
        flash_erase_req = erase;
        flash_wr_req = ~erase;
        flash_addr = a;
        flash_wdata = d;
        cyc(1);
        flash_wr_req = 1'h0;
        flash_erase_req = 1'h0;
    endtask

    // Bounded wait, then two edges for the relock to show
    task automatic wait_done();
        int n;
        n = 0;
        while (flash_op_done !== 1'h1 && n < 100) begin
            cyc(1);
            n++;
        end
        if (n == 100) begin
            fail_count++;
            $display("BAD %0t no completion from array", $time);
            complete_run();
        end
        cyc(2);
    endtask

    task automatic tick(input logic req);
        @(posedge core_clk);
        #1;
        sys_tick = 1'h1;
        flash_read_req = req;
        cyc(1);
        sys_tick = 1'h0;
    endtask

    initial begin
        rst_b = 1'h0;
        sfr_req = '0;
        flash_wr_req = 1'h0;
        flash_erase_req = 1'h0;
        flash_addr = 16'h0000;
        flash_wdata = 8'h00;
        sys_tick = 1'h0;
        flash_read_req = 1'h0;
        sysclk_fast = 1'h0;
        flash_read_timing_select = 1'h0;
        slow = 1'h1;
        bad_key = '{8'h12, 8'ha5, 8'hf1};
        fail_count = 0;
        total_checks = 0;
        do_reset();
        chk(lock_state, 2'h0, "lock after reset");
        chk(prefetch_enable, 1'h1, "prefetch after reset");
        sfr_rd(ADDR_KEY_LOCK, RST_KEY_LOCK);
        sfr_rd(ADDR_STROBE_PER, 8'h0f);
        sfr_rd(ADDR_CACHE_CTRL, RST_CACHE_CTRL);
        sfr_rd(8'h00, 8'h00);
        sfr_wr(ADDR_STROBE_PER, 8'hf3);
        sfr_rd(ADDR_STROBE_PER, 8'h03);
        sfr_wr(ADDR_CACHE_CTRL, 8'h00);
        cyc(1);
        chk(prefetch_enable, 1'h0, "prefetch off");
        sfr_wr(ADDR_KEY_LOCK, KEY_FIRST);
        cyc(1);
        chk(lock_state, 2'h1, "first key seen");
        sfr_wr(ADDR_KEY_LOCK, KEY_SECOND);
        cyc(1);
        chk(lock_state, 2'h2, "unlocked");
        sfr_rd(ADDR_KEY_LOCK, 8'h02);
        flash_op(1'h0, 16'h1234, 8'h5a);
        chk(prog_start, 1'h1, "single start");
        chk(op_refused, 1'h0, "no refusal when open");
        chk(prog_cmd, {2'h0, 16'h1234, 16'h005a}, "single cmd");
        wait_done();
        chk(lock_state, 2'h0, "relock after byte");
        slow = 1'h0;
        sfr_wr(ADDR_CACHE_CTRL, 8'h21);
        sfr_wr(ADDR_KEY_LOCK, KEY_FIRST);
        sfr_wr(ADDR_KEY_LOCK, KEY_SECOND);
        cyc(1);
        flash_op(1'h0, 16'h0100, 8'h11);
        chk(prog_start, 1'h0, "half pair held");
        flash_op(1'h0, 16'h0101, 8'h22);
        chk(prog_start, 1'h1, "pair start");
        chk(prog_cmd, {2'h1, 16'h0100, 16'h2211}, "pair cmd");
        wait_done();
        chk(lock_state, 2'h0, "relock after pair");
        flash_op(1'h1, 16'h0200, 8'h00);
        chk(op_refused, 1'h1, "erase refused");
        chk(prog_start, 1'h0, "no start when locked");
        cyc(2);
        chk(lock_state, 2'h3, "lockout");
        sfr_wr(ADDR_KEY_LOCK, KEY_FIRST);
        sfr_wr(ADDR_KEY_LOCK, KEY_SECOND);
        cyc(1);
        chk(lock_state, 2'h3, "keys ignored");
        flash_op(1'h0, 16'h0300, 8'h33);
        chk(prog_start, 1'h0, "no start in lockout");
        do_reset();
        chk(lock_state, 2'h0, "reset clears lockout");
        // Wrong first key, repeated first key, second key first
        for (int i = 0; i < 3; i++) begin
            sfr_wr(ADDR_KEY_LOCK, bad_key[i]);
            sfr_wr(ADDR_KEY_LOCK, KEY_FIRST);
            cyc(1);
            chk(lock_state, 2'h3, "bad key lockout");
            do_reset();
        end
        // A half-entered key must not survive reset
        sfr_wr(ADDR_KEY_LOCK, KEY_FIRST);
        do_reset();
        sfr_wr(ADDR_KEY_LOCK, KEY_SECOND);
        cyc(1);
        chk(lock_state, 2'h3, "half key survived reset");
        sfr_wr(ADDR_STROBE_PER, 8'h01);
        // Modes: slow clock, fast clock bypass, fast with slow timing
        for (int m = 0; m < 3; m++) begin
            sysclk_fast = (m != 0);
            flash_read_timing_select = (m == 2);
            tick(1'h1);
            chk(read_strobe, 1'h1, "strobe starts");
            cyc(1);
            chk(read_strobe, 1'h1, "strobe width");
            cyc(1);
            chk(read_strobe, m == 1, "strobe end");
            chk(array_low_power, m != 1, "low power");
            tick(1'h0);
            chk(array_low_power, 1'h0, "low power ends");
            chk(read_strobe, 1'h0, "strobe idle");
        end
        complete_run();
    end
endmodule
`default_nettype wire
